/* common/ssr_pin_if.sv */
`timescale 1ns/1ps
interface ssr_pin_if;
   logic [ssr_pkg::DATA_W-1:0] raw;
   logic [ssr_pkg::DATA_W-1:0] synced;
   modport sync (input raw, output synced);
   modport core (output raw, input synced);
endinterface : ssr_pin_if

/* common/ssr_pkg.sv */
package ssr_pkg;
   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int DATA_W = 16;
   localparam int WADDR_W = 20;
   localparam int BADDR_W = 21;
   localparam int BYTE_W = 8;
   localparam int CNT_W = 3;
   localparam int SYNC_STAGES = 2;
   localparam int ADDR_PIN_BIT = 15;
   localparam logic [DATA_W-1:0] OE_NONE = 16'h0000;
   localparam logic [DATA_W-1:0] OE_LOW = 16'h00FF;
   localparam logic [DATA_W-1:0] OE_HIGH = 16'hFF00;
   localparam logic [DATA_W-1:0] OE_LSB_PIN = 16'h8000;
   localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
   localparam logic [WADDR_W-1:0] ADDR_ZERO = 20'h00000;

   // ------------------------------------------------------------
   // Timing, slowest speed grade
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int T_RC_NS = 55;
   localparam int T_WP_NS = 45;
   localparam int T_OHZ_NS = 20;
   function automatic int ceilCyc(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction : ceilCyc
   localparam int RD_CYC = ceilCyc(T_RC_NS);
   localparam int WP_CYC = ceilCyc(T_WP_NS);
   localparam int TURN_CYC = ceilCyc(T_OHZ_NS);
   localparam logic [CNT_W-1:0] RD_WAIT = CNT_W'(RD_CYC + SYNC_STAGES);
   localparam logic [CNT_W-1:0] WP_WAIT = CNT_W'(WP_CYC);
   localparam logic [CNT_W-1:0] TURN_WAIT = CNT_W'(TURN_CYC);
   localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
   localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;

   // ------------------------------------------------------------
   // Controller states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RD_ACC = 3'b001,
      ST_RD_CAP = 3'b010,
      ST_WR_SETUP = 3'b011,
      ST_WR_PULSE = 3'b100,
      ST_WR_HOLD = 3'b101,
      ST_TURN = 3'b110
   } ssr_state_t;
endpackage : ssr_pkg

/* sim/ssr_host_chk.sv */
`timescale 1ns/1ps
module ssr_host_chk
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic [ssr_pkg::BADDR_W-1:0] reqAddr,
   input wire logic reqLowLane,
   input wire logic reqHighLane,
   input wire logic reqReady,
   input wire logic rspValid,
   input wire logic widthSelectN,
   input wire logic selectN,
   input wire logic selectHigh,
   input wire logic storeStrobeN,
   input wire logic driveEnableN,
   input wire logic lowLaneN,
   input wire logic highLaneN,
   input wire logic [ssr_pkg::WADDR_W-1:0] wordAddressPins,
   input wire logic [ssr_pkg::DATA_W-1:0] dataPinsOe
);
   import ssr_pkg::*;
   // ------------------------------------------------------------
   // Sequences
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic selOn;
   logic rdOn;
   assign selOn = !selectN && selectHigh;
   assign rdOn = selOn && !driveEnableN && storeStrobeN;
   sequence rdTake;
      reqValid && reqReady && !reqWrite;
   endsequence
   sequence wrTake;
      reqValid && reqReady && reqWrite;
   endsequence
   sequence strobePulse;
      !storeStrobeN ##1 storeStrobeN;
   endsequence
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   a_strobe_select: assert property (
      !storeStrobeN |-> selOn && !(lowLaneN && highLaneN) && $past(selOn))
      else $error("store strobe without prior select");
   a_write_steps: assert property (
      wrTake |=> storeStrobeN && (widthSelectN ?
      (lowLaneN == !$past(reqLowLane) && highLaneN == !$past(reqHighLane))
      : (!lowLaneN && !highLaneN)) ##1 strobePulse)
      else $error("write lanes or strobe wrong");
   a_pulse_data: assert property (
      $fell(storeStrobeN) |-> dataPinsOe != OE_NONE && driveEnableN)
      else $error("strobe without host data");
   a_read_steps: assert property (
      rdTake |=> rdOn [*5] ##1 (selectN && driveEnableN && rspValid))
      else $error("read sequence wrong");
   a_read_addr: assert property (
      rdTake |=> wordAddressPins == (widthSelectN ? $past(reqAddr[19:0])
      : $past(reqAddr[20:1])))
      else $error("read address wrong");
   a_byte_pin: assert property (
      !widthSelectN && !driveEnableN |-> dataPinsOe == OE_LSB_PIN)
      else $error("byte read drive wrong");
   a_word_clash: assert property (
      widthSelectN && !driveEnableN |-> dataPinsOe == OE_NONE)
      else $error("host drives during read");
   a_byte_lanes: assert property (
      !widthSelectN && !selectN |-> !lowLaneN && !highLaneN)
      else $error("byte width lane high");
   a_width_fixed: assert property (
      reqReady |-> $stable(widthSelectN))
      else $error("width strap moved");
endmodule : ssr_host_chk
bind ssr_host ssr_host_chk u_ssr_host_chk (.*);

/* sim/ssr_host_tb_top.sv */
`timescale 1ns/1ps
module ssr_host_tb_top;
   import ssr_pkg::*;
   logic clk, arst_n, cfgByteMode, reqValid, reqWrite, reqLowLane, reqHighLane;
   logic reqReady, rspValid, widthSelectN, selectN, selectHigh, storeStrobeN;
   logic driveEnableN, lowLaneN, highLaneN;
   logic [BADDR_W-1:0] reqAddr;
   logic [DATA_W-1:0] reqData, rspData, dataPinsIn, dataPinsOut, dataPinsOe;
   logic [WADDR_W-1:0] wordAddressPins;
   int n_errors = 0;
   int check_count = 0;
   int cycles = 0;
   ssr_host u_ssr_host (.*);
   ssr_sram_model u_ssr_sram_model (.*, .hostOut(dataPinsOut),
      .hostOe(dataPinsOe), .bus(dataPinsIn));
   // ------------------------------------------------------------
   // Clock, timeout, tasks
   // ------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Whole run needs about 100 cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 1000)
      begin
         n_errors++;
         tally_and_finish();
      end
   end
   task tally_and_finish;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [15:0] got, exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic boot(input logic byteMode);
      arst_n = 1'b0;
      cfgByteMode = byteMode;
      repeat (2) @(posedge clk);
      #2;
      chk({13'h0, selectN, storeStrobeN, driveEnableN}, 16'h0007, "idle");
      chk(dataPinsOe, OE_NONE, "idle drive");
      arst_n = 1'b1;
      @(posedge clk);
      #2;
      chk({15'h0, widthSelectN}, {15'h0, !byteMode}, "strap");
   endtask : boot
   task automatic req(input logic wr, input logic [20:0] a,
                      input logic [15:0] d, input logic lo, hi);
      int n;
      n = 0;
      while (reqReady !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         #2;
         n++;
      end
      {reqValid, reqWrite, reqAddr, reqData} = {1'b1, wr, a, d};
      {reqLowLane, reqHighLane} = {lo, hi};
      @(posedge clk);
      #2;
      reqValid = 1'b0;
   endtask : req
   task automatic rd(input logic [20:0] a, input logic lo, hi,
                     input logic [15:0] exp);
      req(1'b0, a, 16'h0000, lo, hi);
      repeat (5) @(posedge clk);
      #2;
      chk({15'h0, rspValid}, 16'h0001, "answer");
      chk(rspData, exp, "read data");
   endtask : rd
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial
   begin
      {arst_n, cfgByteMode, reqValid, reqWrite, reqLowLane, reqHighLane} = '0;
      reqAddr = '0;
      reqData = '0;
      boot(1'b0);
      req(1'b1, 21'h000005, 16'h1234, 1'b1, 1'b1);
      req(1'b1, 21'h000005, 16'hFFAB, 1'b1, 1'b0);
      req(1'b1, 21'h000005, 16'hCDEE, 1'b0, 1'b1);
      req(1'b1, 21'h0FFFFF, 16'h8001, 1'b1, 1'b1);
      rd(21'h000005, 1'b1, 1'b1, 16'hCDAB);
      rd(21'h000005, 1'b1, 1'b0, 16'h00AB);
      rd(21'h000005, 1'b0, 1'b1, 16'hCD00);
      rd(21'h0FFFFF, 1'b1, 1'b1, 16'h8001);
      boot(1'b1);
      req(1'b1, 21'h00000A, 16'hEE5A, 1'b0, 1'b0);
      req(1'b1, 21'h00000B, 16'h77C3, 1'b1, 1'b1);
      req(1'b1, 21'h1FFFFF, 16'h0042, 1'b0, 1'b0);
      rd(21'h00000A, 1'b0, 1'b0, 16'h005A);
      rd(21'h00000B, 1'b0, 1'b0, 16'h00C3);
      rd(21'h1FFFFE, 1'b0, 1'b0, 16'h0001);
      boot(1'b0);
      rd(21'h000005, 1'b1, 1'b1, 16'hC35A);
      rd(21'h0FFFFF, 1'b1, 1'b1, 16'h4201);
      tally_and_finish();
   end
endmodule : ssr_host_tb_top

/* sim/ssr_sram_model.sv */
`timescale 1ns/1ps
module ssr_sram_model
#(
   parameter bit LSB_HIGH_HALF = 1'b0
)
(
   input wire logic clk,
   input wire logic widthSelectN,
   input wire logic selectN,
   input wire logic selectHigh,
   input wire logic storeStrobeN,
   input wire logic driveEnableN,
   input wire logic lowLaneN,
   input wire logic highLaneN,
   input wire logic [ssr_pkg::WADDR_W-1:0] wordAddressPins,
   input wire logic [ssr_pkg::DATA_W-1:0] hostOut,
   input wire logic [ssr_pkg::DATA_W-1:0] hostOe,
   output logic [ssr_pkg::DATA_W-1:0] bus
);
   import ssr_pkg::*;
   // ------------------------------------------------------------
   // Storage and pins
   // ------------------------------------------------------------
   logic [DATA_W-1:0] mem [0:(1<<WADDR_W)-1];
   logic [DATA_W-1:0] devOe, devOut, word;
   logic [DATA_W-1:0] flt = 16'hA5A5;
   logic sel, hiHalf;
   assign sel = !selectN && selectHigh && !(lowLaneN && highLaneN);
   assign hiHalf = bus[ADDR_PIN_BIT] ^ LSB_HIGH_HALF;
   // Floating pins toggle so a stale value never looks valid
   always @(posedge clk) flt <= ~flt;
   assign bus = (hostOe & hostOut) | (devOe & devOut)
                | (~(hostOe | devOe) & flt);
   assign word = mem[wordAddressPins];
   always_comb
   begin
      devOe = OE_NONE;
      devOut = DATA_ZERO;
      // Never drives while the strobe is low, so a late select stays off
      if (sel && storeStrobeN && !driveEnableN)
      begin
         devOe = widthSelectN ? {{8{!highLaneN}}, {8{!lowLaneN}}}
                 : OE_LOW;
         devOut = widthSelectN ? word
                  : {8'h00, hiHalf ? word[15:8] : word[7:0]};
      end
   end
   // Stored at the edge that closes the strobe cycle, from the held pins
   always @(posedge clk)
   begin
      if (sel && !storeStrobeN)
      begin
         if (widthSelectN)
            mem[wordAddressPins] <= {highLaneN ? word[15:8] : bus[15:8],
                                     lowLaneN ? word[7:0] : bus[7:0]};
         else if (hiHalf)
            mem[wordAddressPins] <= {bus[7:0], word[7:0]};
         else
            mem[wordAddressPins] <= {word[15:8], bus[7:0]};
      end
   end
endmodule : ssr_sram_model

/* verilog/ssr_host.sv */
`timescale 1ns/1ps
module ssr_host
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic cfgByteMode,
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic [ssr_pkg::BADDR_W-1:0] reqAddr,
   input wire logic [ssr_pkg::DATA_W-1:0] reqData,
   input wire logic reqLowLane,
   input wire logic reqHighLane,
   output logic reqReady,
   output logic rspValid,
   output logic [ssr_pkg::DATA_W-1:0] rspData,
   output logic widthSelectN,
   output logic selectN,
   output logic selectHigh,
   output logic storeStrobeN,
   output logic driveEnableN,
   output logic lowLaneN,
   output logic highLaneN,
   output logic [ssr_pkg::WADDR_W-1:0] wordAddressPins,
   input wire logic [ssr_pkg::DATA_W-1:0] dataPinsIn,
   output logic [ssr_pkg::DATA_W-1:0] dataPinsOut,
   output logic [ssr_pkg::DATA_W-1:0] dataPinsOe
);
   import ssr_pkg::*;

   // ------------------------------------------------------------
   // Decoding helpers
   // ------------------------------------------------------------
   // Lane selects, active low; byte width forces both low
   function automatic logic [1:0] laneSelN(input logic byteM,
                                           input logic lo,
                                           input logic hi);
      return byteM ? 2'b00 : {~hi, ~lo};
   endfunction : laneSelN

   // Data bits that belong to the selected lanes; byte width gives the low lane only
   function automatic logic [DATA_W-1:0] laneMask(input logic byteM,
                                                  input logic [1:0] selN);
      logic [DATA_W-1:0] m;
      m = OE_NONE;
      if (byteM)
         m = OE_LOW;
      else
      begin
         if (!selN[0])
            m = m | OE_LOW;
         if (!selN[1])
            m = m | OE_HIGH;
      end
      return m;
   endfunction : laneMask

   // ------------------------------------------------------------
   // Pin synchroniser
   // ------------------------------------------------------------
   ssr_pin_if pinIf ();
   assign pinIf.raw = dataPinsIn;

   ssr_pin_sync uSync
   (
      .clk(clk),
      .arst_n(arst_n),
      .pins(pinIf)
   );

   // ------------------------------------------------------------
   // Width strap, caught once after reset release
   // ------------------------------------------------------------
   logic strapDone_r;
   logic widthSelN_r;
   logic byteMode;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         strapDone_r <= 1'b0;
         widthSelN_r <= 1'b1;
      end
      else if (!strapDone_r)
      begin
         strapDone_r <= 1'b1;
         widthSelN_r <= ~cfgByteMode;
      end
   end

   assign byteMode = ~widthSelN_r;
   assign widthSelectN = widthSelN_r;

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   ssr_state_t state_r;
   ssr_state_t state_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic accept;
   logic [1:0] laneReqN;
   logic [1:0] laneN_r;
   logic [DATA_W-1:0] mask_r;

   assign accept = reqValid && reqReady && strapDone_r;
   assign laneReqN = laneSelN(byteMode, reqLowLane, reqHighLane);

   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt = (cnt_r == CNT_ZERO) ? CNT_ZERO : cnt_r - CNT_ONE;
      unique case (state_r)
         ST_IDLE:
            if (accept)
            begin
               state_nxt = reqWrite ? ST_WR_SETUP : ST_RD_ACC;
               cnt_nxt = reqWrite ? WP_WAIT : RD_WAIT;
            end
         ST_RD_ACC:
            if (cnt_r == CNT_ONE)
               state_nxt = ST_RD_CAP;
         ST_RD_CAP:
         begin
            state_nxt = ST_TURN;
            cnt_nxt = TURN_WAIT;
         end
         ST_WR_SETUP:
         begin
            // Count is held here so the pulse gets its full length
            state_nxt = ST_WR_PULSE;
            cnt_nxt = cnt_r;
         end
         ST_WR_PULSE:
            if (cnt_r == CNT_ONE)
               state_nxt = ST_WR_HOLD;
         ST_WR_HOLD:
            state_nxt = ST_IDLE;
         ST_TURN:
            if (cnt_r <= CNT_ONE)
               state_nxt = ST_IDLE;
         default:
            state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_r <= ST_IDLE;
         cnt_r <= CNT_ZERO;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // ------------------------------------------------------------
   // Memory control strobes
   // ------------------------------------------------------------
   // Deselect between accesses keeps the part in standby
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         selectN <= 1'b1;
         selectHigh <= 1'b0;
         storeStrobeN <= 1'b1;
         driveEnableN <= 1'b1;
         lowLaneN <= 1'b1;
         highLaneN <= 1'b1;
      end
      else
      begin
         selectN <= !(state_nxt inside {ST_RD_ACC, ST_RD_CAP,
                      ST_WR_SETUP, ST_WR_PULSE});
         selectHigh <= state_nxt inside {ST_RD_ACC, ST_RD_CAP,
                       ST_WR_SETUP, ST_WR_PULSE};
         storeStrobeN <= (state_nxt != ST_WR_PULSE);
         // Output drive only in reads, so writes never fight it
         driveEnableN <= !(state_nxt inside {ST_RD_ACC,
                           ST_RD_CAP});
         if (accept)
         begin
            lowLaneN <= laneReqN[0];
            highLaneN <= laneReqN[1];
         end
         else if (state_nxt == ST_IDLE || state_nxt == ST_TURN)
         begin
            lowLaneN <= !byteMode;
            highLaneN <= !byteMode;
         end
      end
   end

   // ------------------------------------------------------------
   // Address and host data drive
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wordAddressPins <= ADDR_ZERO;
         dataPinsOut <= DATA_ZERO;
         dataPinsOe <= OE_NONE;
         laneN_r <= 2'h3;
         mask_r <= OE_NONE;
      end
      else
      begin
         if (accept)
         begin
            laneN_r <= laneReqN;
            mask_r <= laneMask(byteMode, laneReqN);
            // Address changes on the same edge as the selects, never later
            wordAddressPins <= byteMode ? reqAddr[BADDR_W-1:1]
                               : reqAddr[WADDR_W-1:0];
            if (byteMode)
               dataPinsOut <= {reqAddr[0], 7'h00,
                               reqData[BYTE_W-1:0]};
            else
               dataPinsOut <= reqData;
         end
         unique case (state_nxt)
            ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD:
               dataPinsOe <= byteMode ? (OE_LOW | OE_LSB_PIN)
                             : laneMask(byteMode,
                                        laneN_r);
            ST_RD_ACC, ST_RD_CAP:
               dataPinsOe <= byteMode ? OE_LSB_PIN : OE_NONE;
            default:
               dataPinsOe <= OE_NONE;
         endcase
         if (accept && reqWrite)
            dataPinsOe <= OE_NONE;
      end
   end

   // ------------------------------------------------------------
   // Read return
   // ------------------------------------------------------------
   // Synced data lags the pins by two edges, covered by RD_WAIT
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rspValid <= 1'b0;
         rspData <= DATA_ZERO;
      end
      else
      begin
         rspValid <= (state_r == ST_RD_CAP);
         if (state_r == ST_RD_CAP)
            rspData <= pinIf.synced & mask_r;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         reqReady <= 1'b0;
      else
         reqReady <= (state_nxt == ST_IDLE) && !accept && strapDone_r;
   end
endmodule : ssr_host

/* verilog/ssr_pin_sync.sv */
`timescale 1ns/1ps
module ssr_pin_sync
(
   input wire logic clk,
   input wire logic arst_n,
   ssr_pin_if.sync pins
);
   import ssr_pkg::*;

   // ------------------------------------------------------------
   // Two-stage capture of the asynchronous data pins
   // ------------------------------------------------------------
   logic [DATA_W-1:0] meta_r;
   logic [DATA_W-1:0] stable_r;

   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta_r <= DATA_ZERO;
         stable_r <= DATA_ZERO;
      end
      else
      begin
         meta_r <= pins.raw;
         stable_r <= meta_r;
      end
   end

   assign pins.synced = stable_r;
endmodule : ssr_pin_sync
